//--- hw/spcx_defs.vh
// Constants for the serial port control, exception and pin port block.
`ifndef SPCX_DEFS_VH
`define SPCX_DEFS_VH
`define SPCX_ADDR_CTRL     4'h0
`define SPCX_ADDR_STATUS   4'h1
`define SPCX_ADDR_RXDATA   4'h2
`define SPCX_ADDR_TXDATA   4'h3
`define SPCX_ADDR_PINFUNC  4'h4
`define SPCX_ADDR_PINDIR   4'h5
`define SPCX_ADDR_PINDATA  4'h6
`define SPCX_ADDR_IRQVEC   4'h7
`define SPCX_ADDR_ACK      4'h8
`define SPCX_ADDR_CLKCTRL  4'h9
`define SPCX_CTRL_TE       1
`define SPCX_CTRL_RE       2
`define SPCX_CTRL_SBK      3
`define SPCX_CTRL_SYNC     4
`define SPCX_CTRL_IDLE_LINE_IRQ_ENABLE     10
`define SPCX_CTRL_RIE      11
`define SPCX_CTRL_TIE      12
`define SPCX_CTRL_BAUD_TIMER_IRQ_ENABLE     13
`define SPCX_CTRL_DMA      14
`define SPCX_CTRL_WL11     15
`define SPCX_CTRL_RECEIVE_ERROR_IRQ_ENABLE     16
`define SPCX_CTRL_RESET    24'h000000
`define SPCX_PIN_RESET     3'h0
`define SPCX_CLK_RESET     12'h00F
`define SPCX_ST_TRANSMIT_REGISTER_EMPTY_FLAG       1
`define SPCX_ST_RDRF       2
`define SPCX_ST_IDLE       3
`define SPCX_ST_PE         4
`define SPCX_ST_FE         5
`define SPCX_ST_OR         6
`define SPCX_PIN_RXD       0
`define SPCX_PIN_TXD       1
`define SPCX_PIN_SCLK      2
`define SPCX_SRC_RXERR     3'h1
`define SPCX_SRC_RX        3'h2
`define SPCX_SRC_TX        3'h3
`define SPCX_SRC_IDLE      3'h4
`define SPCX_SRC_TIMER     3'h5
`define SPCX_SRC_NONE      3'h0
`define SPCX_PREAMBLE_BITS 4'hA
`endif

//--- hw/spcx_top.v
// Serial port control, start-up, exception and shared pin port logic.
`timescale 1ns/1ps
`include "spcx_defs.vh"
module spcx_top #(
  parameter DATA_W = 8
) (
  // Clock, reset and enable
  input  wire        SYS_CLK,
  input  wire        RST_N,
  input  wire        CLK_EN,
  // Avalon-MM slave
  input  wire [3:0]  AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [31:0] AVS_WRITEDATA,
  output reg  [31:0] AVS_READDATA,
  output wire        AVS_WAITREQUEST,
  // Interrupt and DMA requests
  output wire        IRQ,
  output wire [2:0]  IRQ_SOURCE,
  output wire        DMA_REQ,
  // Pins: receive data, transmit data, serial clock
  input  wire [2:0]  PIN_IN,
  output reg  [2:0]  PIN_OUT,
  output reg  [2:0]  PIN_OE
);
  reg  [23:0] ctrl;
  reg  [11:0] clk_div;
  reg  [2:0]  pin_func;
  reg  [2:0]  pin_dir;
  reg  [2:0]  pin_data;
  reg  [2:0]  pin_s1;
  reg  [2:0]  pin_s2;
  reg  [DATA_W-1:0] rx_data;
  reg  [DATA_W-1:0] tx_data;
  reg         transmit_register_empty_flag;
  reg         rdrf;
  reg         pe;
  reg         fe;
  reg         ovr;
  reg         idle_flag;
  reg         timer_flag;
  reg         stat_read;
  reg  [11:0] baud_cnt;
  reg         sclk;
  reg  [3:0]  idle_cnt;
  reg         rx_armed;
  reg         rx_busy;
  reg  [3:0]  rx_bit;
  reg  [DATA_W:0] rx_shift;
  reg         rx_prev;
  reg         tx_busy;
  reg  [3:0]  tx_bit;
  reg  [DATA_W+1:0] tx_shift;
  reg         tx_line;
  reg         pre_pend;
  reg         brk_pend;
  reg         sbk_prev;
  reg         te_prev;
  reg         ack_pulse;
  reg         ready;
  wire        port_rst   = (pin_func == 3'h0);
  wire        te         = ctrl[`SPCX_CTRL_TE];
  wire        re         = ctrl[`SPCX_CTRL_RE];
  wire        active     = ~port_rst & (te | re);
  wire        tick       = (baud_cnt == 12'h000);
  wire        req        = (AVS_READ | AVS_WRITE) & ~ready;
  wire        wr         = AVS_WRITE & ready;
  wire        rd         = AVS_READ & ready;
  wire        rxd        = pin_s2[`SPCX_PIN_RXD];
  wire [3:0]  frame_ones = ctrl[`SPCX_CTRL_WL11] ? 4'hB : 4'hA;
  wire        src_err    = rdrf & (pe | fe | ovr) & ctrl[`SPCX_CTRL_RECEIVE_ERROR_IRQ_ENABLE];
  wire        src_rx     = rdrf & ~(pe | fe | ovr) & ctrl[`SPCX_CTRL_RIE];
  wire        src_tx     = transmit_register_empty_flag & ctrl[`SPCX_CTRL_TIE] & ~ctrl[`SPCX_CTRL_DMA];
  wire        src_idle   = idle_flag & ctrl[`SPCX_CTRL_IDLE_LINE_IRQ_ENABLE];
  wire        src_tmr    = timer_flag & ctrl[`SPCX_CTRL_BAUD_TIMER_IRQ_ENABLE];
  reg  [2:0]  next_src;
  wire [11:0] status = {5'h00, ovr, fe, pe, idle_flag, rdrf, transmit_register_empty_flag, 1'b0};
  localparam [3:0] data_bits = DATA_W;

  // One wait state keeps every access the same length and registers read data.
  assign AVS_WAITREQUEST = req;

  always @*
  begin
    next_src = `SPCX_SRC_NONE;
    if (active)
    begin
      if (src_err)
        next_src = `SPCX_SRC_RXERR;
      else if (src_rx)
        next_src = `SPCX_SRC_RX;
      else if (src_tx)
        next_src = `SPCX_SRC_TX;
      else if (src_idle)
        next_src = `SPCX_SRC_IDLE;
      else if (src_tmr)
        next_src = `SPCX_SRC_TIMER;
    end
  end
  assign IRQ_SOURCE = next_src;
  assign IRQ        = (next_src != `SPCX_SRC_NONE);
  assign DMA_REQ    = active & te & transmit_register_empty_flag & ctrl[`SPCX_CTRL_DMA];

  // Bus slave, registers and pin port.
  always @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      ready        <= 1'b0;
      AVS_READDATA <= 32'h00000000;
      ctrl         <= `SPCX_CTRL_RESET;
      clk_div      <= `SPCX_CLK_RESET;
      pin_func     <= `SPCX_PIN_RESET;
      pin_dir      <= `SPCX_PIN_RESET;
      pin_data     <= `SPCX_PIN_RESET;
      pin_s1       <= 3'h0;
      pin_s2       <= 3'h0;
      ack_pulse    <= 1'b0;
    end
    else if (CLK_EN)
    begin
      pin_s1    <= PIN_IN;
      pin_s2    <= pin_s1;
      ready     <= req;
      ack_pulse <= 1'b0;
      // Read data is registered in the wait cycle so it stands at the accepting edge.
      if (AVS_READ && !ready)
      begin
        case (AVS_ADDRESS)
          `SPCX_ADDR_CTRL:    AVS_READDATA <= {8'h00, ctrl};
          `SPCX_ADDR_STATUS:  AVS_READDATA <= {20'h00000, status};
          `SPCX_ADDR_RXDATA:  AVS_READDATA <= {{(32-DATA_W){1'b0}}, rx_data};
          `SPCX_ADDR_PINFUNC: AVS_READDATA <= {29'h0, pin_func};
          `SPCX_ADDR_PINDIR:  AVS_READDATA <= {29'h0, pin_dir};
          `SPCX_ADDR_PINDATA: AVS_READDATA <= {29'h0, pin_data};
          `SPCX_ADDR_IRQVEC:  AVS_READDATA <= {29'h0, next_src};
          `SPCX_ADDR_CLKCTRL: AVS_READDATA <= {20'h00000, clk_div};
          default:            AVS_READDATA <= 32'h00000000;
        endcase
      end
      if (wr)
      begin
        case (AVS_ADDRESS)
          `SPCX_ADDR_CTRL:    ctrl     <= AVS_WRITEDATA[23:0];
          `SPCX_ADDR_PINFUNC: pin_func <= AVS_WRITEDATA[2:0];
          `SPCX_ADDR_PINDIR:  pin_dir  <= AVS_WRITEDATA[2:0];
          `SPCX_ADDR_CLKCTRL: clk_div  <= AVS_WRITEDATA[11:0];
          `SPCX_ADDR_ACK:     ack_pulse <= 1'b1;
          default:            ack_pulse <= 1'b0;
        endcase
      end
      // Input bits follow the pin; a write only lands on output bits.
      pin_data <= (pin_s2 & ~pin_dir & ~pin_func) | (pin_data & (pin_dir | pin_func));
      if (wr && AVS_ADDRESS == `SPCX_ADDR_PINDATA)
        pin_data <= (AVS_WRITEDATA[2:0] & (pin_dir | pin_func)) | (pin_s2 & ~pin_dir & ~pin_func);
    end
  end

  // Pin multiplexing: serial function wins over direction.
  always @*
  begin
    PIN_OUT = pin_data;
    PIN_OE  = pin_dir & ~pin_func;
    if (pin_func[`SPCX_PIN_TXD])
    begin
      PIN_OUT[`SPCX_PIN_TXD] = tx_line;
      PIN_OE[`SPCX_PIN_TXD]  = 1'b1;
    end
    if (pin_func[`SPCX_PIN_SCLK])
    begin
      PIN_OUT[`SPCX_PIN_SCLK] = sclk;
      PIN_OE[`SPCX_PIN_SCLK]  = 1'b1;
    end
  end

  // Serial engine; held in its own reset while no pin is serial.
  always @(posedge SYS_CLK)
  begin
    if (!RST_N || (CLK_EN && port_rst))
    begin
      baud_cnt   <= 12'h000;
      sclk       <= 1'b0;
      transmit_register_empty_flag       <= 1'b1;
      rdrf       <= 1'b0;
      pe         <= 1'b0;
      fe         <= 1'b0;
      ovr        <= 1'b0;
      idle_flag  <= 1'b0;
      timer_flag <= 1'b0;
      stat_read  <= 1'b0;
      rx_data    <= {DATA_W{1'b0}};
      tx_data    <= {DATA_W{1'b0}};
      idle_cnt   <= 4'h0;
      rx_armed   <= 1'b0;
      rx_busy    <= 1'b0;
      rx_bit     <= 4'h0;
      rx_shift   <= {(DATA_W+1){1'b0}};
      rx_prev    <= 1'b1;
      tx_busy    <= 1'b0;
      tx_bit     <= 4'h0;
      tx_shift   <= {(DATA_W+2){1'b1}};
      tx_line    <= 1'b1;
      pre_pend   <= 1'b0;
      brk_pend   <= 1'b0;
      sbk_prev   <= 1'b0;
      te_prev    <= 1'b0;
    end
    else if (CLK_EN)
    begin
      baud_cnt <= tick ? clk_div : baud_cnt - 12'h001;
      if (tick)
        timer_flag <= 1'b1;
      else if (ack_pulse && next_src == `SPCX_SRC_TIMER)
        timer_flag <= 1'b0;
      if (tick)
        sclk <= ctrl[`SPCX_CTRL_SYNC] ? (tx_busy & ~sclk) : ~sclk;
      te_prev  <= te;
      sbk_prev <= ctrl[`SPCX_CTRL_SBK];
      if (te & ~te_prev)
        pre_pend <= 1'b1;
      if (ctrl[`SPCX_CTRL_SBK] != sbk_prev)
        brk_pend <= 1'b1;
      // Status read arms the error clear; the next data read completes it.
      if (rd && AVS_ADDRESS == `SPCX_ADDR_STATUS)
        stat_read <= 1'b1;
      if (rd && AVS_ADDRESS == `SPCX_ADDR_RXDATA)
      begin
        rdrf      <= 1'b0;
        stat_read <= 1'b0;
        if (stat_read)
        begin
          pe  <= 1'b0;
          fe  <= 1'b0;
          ovr <= 1'b0;
        end
      end
      if (wr && AVS_ADDRESS == `SPCX_ADDR_TXDATA)
      begin
        tx_data <= AVS_WRITEDATA[DATA_W-1:0];
        transmit_register_empty_flag    <= 1'b0;
      end
      // Receiver: sample one bit per baud tick, start only after an idle line.
      if (tick)
      begin
        rx_prev <= rxd;
        if (!re)
        begin
          rx_armed <= 1'b0;
          rx_busy  <= 1'b0;
          idle_cnt <= 4'h0;
        end
        else if (rx_busy)
        begin
          rx_shift <= {rxd, rx_shift[DATA_W:1]};
          rx_bit   <= rx_bit + 4'h1;
          if (rx_bit == data_bits)
          begin
            rx_busy <= 1'b0;
            rx_data <= rx_shift[DATA_W:1];
            rdrf    <= 1'b1;
            fe      <= ~rxd;
            pe      <= 1'b0;
            if (rdrf)
              ovr <= 1'b1;
          end
        end
        else if (rxd)
        begin
          if (idle_cnt != 4'hF)
            idle_cnt <= idle_cnt + 4'h1;
          if (idle_cnt + 4'h1 == frame_ones)
          begin
            rx_armed  <= 1'b1;
            idle_flag <= 1'b1;
          end
        end
        else
        begin
          idle_cnt <= 4'h0;
          if (rx_armed && rx_prev)
          begin
            rx_busy <= 1'b1;
            rx_bit  <= 4'h0;
          end
        end
      end
      if (ack_pulse && next_src == `SPCX_SRC_IDLE && !(tick && rxd && idle_cnt + 4'h1 == frame_ones))
        idle_flag <= 1'b0;
      // Transmitter: choose pending work only between characters.
      if (tick && !sclk)
      begin
        if (tx_busy)
        begin
          tx_line  <= tx_shift[0];
          tx_shift <= {1'b1, tx_shift[DATA_W+1:1]};
          tx_bit   <= tx_bit - 4'h1;
          if (tx_bit == 4'h1)
            tx_busy <= 1'b0;
        end
        else if (!te)
          tx_line <= 1'b1;
        else if (pre_pend)
        begin
          pre_pend <= 1'b0;
          tx_shift <= {(DATA_W+2){1'b1}};
          tx_bit   <= `SPCX_PREAMBLE_BITS;
          tx_busy  <= 1'b1;
        end
        else if (brk_pend)
        begin
          brk_pend <= 1'b0;
          tx_shift <= {(DATA_W+2){1'b0}};
          tx_bit   <= `SPCX_PREAMBLE_BITS;
          tx_busy  <= 1'b1;
        end
        else if (!transmit_register_empty_flag && !(wr && AVS_ADDRESS == `SPCX_ADDR_TXDATA))
        begin
          tx_shift <= {1'b1, tx_data, 1'b0};
          tx_bit   <= data_bits + 4'h2;
          tx_busy  <= 1'b1;
          transmit_register_empty_flag     <= 1'b1;
        end
      end
    end
  end
endmodule

//--- bench/spcx_top_assertions.sv
// Checker of bus timing, pin port and interrupt source behaviour.
`timescale 1ns/1ps
`include "spcx_defs.vh"
module spcx_chk (
  // Clock and reset
  input wire        SYS_CLK,
  input wire        RST_N,
  input wire        CLK_EN,
  // Bus
  input wire [3:0]  AVS_ADDRESS,
  input wire        AVS_READ,
  input wire        AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [31:0] AVS_READDATA,
  input wire        AVS_WAITREQUEST,
  // Requests and pins
  input wire        IRQ,
  input wire [2:0]  IRQ_SOURCE,
  input wire        DMA_REQ,
  input wire [2:0]  PIN_IN,
  input wire [2:0]  PIN_OUT,
  input wire [2:0]  PIN_OE
);
  reg  [2:0] fn;
  reg  [2:0] dr;
  reg  [2:0] dt;
  reg  [4:0] cr;
  wire       wa = AVS_WRITE && !AVS_WAITREQUEST;
  wire       ra = AVS_READ && !AVS_WAITREQUEST;
  // Shadow copies of what software wrote, so pin checks need no internal probes.
  always @(posedge SYS_CLK)
    if (!RST_N)
    begin
      fn <= 3'h0;
      dr <= 3'h0;
      dt <= 3'h0;
      cr <= 5'h00;
    end
    else if (wa)
    begin
      if (AVS_ADDRESS == `SPCX_ADDR_PINFUNC) fn <= AVS_WRITEDATA[2:0];
      if (AVS_ADDRESS == `SPCX_ADDR_PINDIR) dr <= AVS_WRITEDATA[2:0];
      if (AVS_ADDRESS == `SPCX_ADDR_PINDATA) dt <= AVS_WRITEDATA[2:0];
      if (AVS_ADDRESS == `SPCX_ADDR_CTRL) cr <= AVS_WRITEDATA[4:0];
    end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  a_one_wait: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("waitrequest held too long");
  a_src_flag: assert property (IRQ == (IRQ_SOURCE != `SPCX_SRC_NONE))
    else $error("irq and source disagree");
  a_port_reset: assert property (fn == 3'h0 |-> !IRQ && !DMA_REQ)
    else $error("request while port held in reset");
  a_disabled_quiet: assert property (!cr[`SPCX_CTRL_TE] && !cr[`SPCX_CTRL_RE] |-> !IRQ)
    else $error("irq with both directions disabled");
  a_gpio_dir: assert property ((~fn & PIN_OE) == (~fn & dr))
    else $error("pin enable differs from direction");
  a_gpio_out: assert property ((~fn & dr & PIN_OUT) == (~fn & dr & dt))
    else $error("pin level differs from data");
  a_sclk_drive: assert property (fn[2] && !cr[`SPCX_CTRL_SYNC] |-> PIN_OE[2])
    else $error("serial clock pin not driven");
  a_sclk_runs: assert property (fn[2] && !cr[`SPCX_CTRL_SYNC] |-> ##[1:40] $changed(PIN_OUT[2]))
    else $error("serial clock stands still");
  a_tx_clear: assert property (wa && AVS_ADDRESS == `SPCX_ADDR_TXDATA |=> IRQ_SOURCE != `SPCX_SRC_TX)
    else $error("transmit source not cleared");
  a_rx_clear: assert property (ra && AVS_ADDRESS == `SPCX_ADDR_RXDATA |=> IRQ_SOURCE != `SPCX_SRC_RX)
    else $error("receive source not cleared");
  a_timer_ack: assert property (wa && AVS_ADDRESS == `SPCX_ADDR_ACK && IRQ_SOURCE == `SPCX_SRC_TIMER
    |=> ##1 IRQ_SOURCE != `SPCX_SRC_TIMER)
    else $error("timer source not cleared");
  c_tx: cover property (IRQ_SOURCE == `SPCX_SRC_TX);
  c_rx: cover property (IRQ_SOURCE == `SPCX_SRC_RX);
  c_err: cover property (IRQ_SOURCE == `SPCX_SRC_RXERR);
endmodule
bind spcx_top spcx_chk u_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .IRQ(IRQ), .IRQ_SOURCE(IRQ_SOURCE), .DMA_REQ(DMA_REQ), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
  .PIN_OE(PIN_OE));

//--- bench/spcx_far_end.sv
// Far side model: remote serial transmitter and the levels on the shared pins.
`timescale 1ns/1ps
module spcx_far_end (
  // Clock and levels
  input  wire       clk,
  input  wire [2:0] lvl,
  input  wire       run_clk,
  // Pins
  input  wire [2:0] pin_oe,
  input  wire [2:0] pin_out,
  output wire [2:0] pin_in
);
  reg rxd = 1'b1;
  reg lclk = 1'b0;
  // The link clock stands still between bursts.
  always #24 lclk = run_clk ? ~lclk : lclk;
  assign pin_in[0] = pin_oe[0] ? pin_out[0] : rxd;
  assign pin_in[1] = pin_oe[1] ? pin_out[1] : lvl[1];
  assign pin_in[2] = pin_oe[2] ? pin_out[2] : (run_clk ? lclk : lvl[2]);
  // Start zero, eight bits lowest first, stop level; one bit lasts one baud tick.
  task send(input [7:0] d, input stp);
    reg     [9:0] f;
    integer       k;
    begin
      f = {stp, d, 1'b0};
      for (k = 0; k < 10; k = k + 1)
      begin
        rxd <= f[k];
        repeat (16) @(posedge clk);
      end
      rxd <= 1'b1;
    end
  endtask
endmodule

//--- bench/spcx_top_tb.sv
// Bench for the serial port control, exception and pin port block.
`timescale 1ns/1ps
`include "spcx_defs.vh"
module spcx_top_tb;
  localparam [31:0] t_en = 32'h1 << `SPCX_CTRL_TE, r_en = 32'h1 << `SPCX_CTRL_RE;
  localparam [31:0] dma = 32'h1 << `SPCX_CTRL_DMA, ie_il = 32'h1 << `SPCX_CTRL_IDLE_LINE_IRQ_ENABLE;
  localparam [31:0] ie_rx = 32'h1 << `SPCX_CTRL_RIE, ie_tx = 32'h1 << `SPCX_CTRL_TIE;
  localparam [31:0] ie_tm = 32'h1 << `SPCX_CTRL_BAUD_TIMER_IRQ_ENABLE, ie_er = 32'h1 << `SPCX_CTRL_RECEIVE_ERROR_IRQ_ENABLE;
  reg         SYS_CLK = 1'b0;
  reg         RST_N = 1'b0;
  reg  [3:0]  AVS_ADDRESS = 4'h0;
  reg         AVS_READ = 1'b0;
  reg         AVS_WRITE = 1'b0;
  reg  [31:0] AVS_WRITEDATA = 32'h0;
  wire [31:0] AVS_READDATA;
  wire        AVS_WAITREQUEST;
  wire        IRQ;
  wire [2:0]  IRQ_SOURCE;
  wire        DMA_REQ;
  wire [2:0]  PIN_IN;
  wire [2:0]  PIN_OUT;
  wire [2:0]  PIN_OE;
  reg  [2:0]  lvl = 3'h0;
  reg         run_clk = 1'b0;
  reg  [31:0] q;
  reg  [1:0]  seen;
  integer     bad_count = 0;
  integer     checked = 0;
  integer     n;
  integer     i;
  always #2.5 SYS_CLK = ~SYS_CLK;
  spcx_top uut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CLK_EN(1'b1), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ),
    .IRQ_SOURCE(IRQ_SOURCE), .DMA_REQ(DMA_REQ), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE));
  spcx_far_end far (.clk(SYS_CLK), .lvl(lvl), .run_clk(run_clk), .pin_oe(PIN_OE),
    .pin_out(PIN_OUT), .pin_in(PIN_IN));
  task check(input [31:0] v, input [31:0] e);
    begin
      checked = checked + 1;
      if (v !== e)
      begin
        bad_count = bad_count + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, v, e);
      end
    end
  endtask
  // Holds the request until waitrequest is sampled low; read data is taken at that edge.
  task bus(input w, input [3:0] a, input [31:0] d);
    begin
      @(posedge SYS_CLK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_WRITE <= w;
      AVS_READ <= !w;
      n = 0;
      // Waitrequest is looked at where it is settled, ahead of the edge that samples it.
      @(negedge SYS_CLK);
      while (AVS_WAITREQUEST !== 1'b0 && n < 50)
      begin
        @(negedge SYS_CLK);
        n = n + 1;
      end
      if (n == 50) bad_count = bad_count + 1;
      @(posedge SYS_CLK);
      q = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
      @(posedge SYS_CLK);
      @(negedge SYS_CLK);
    end
  endtask
  task rdc(input [3:0] a, input [31:0] m, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      check(q & m, e);
    end
  endtask
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial
  begin
    repeat (20000) @(posedge SYS_CLK);
    bad_count = bad_count + 1;
    print_verdict;
  end
  initial
  begin
    repeat (12) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    @(posedge SYS_CLK);
    rdc(`SPCX_ADDR_PINFUNC, 32'hFFFFFFFF, 32'h0);
    rdc(`SPCX_ADDR_PINDIR, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, 4'hF, 32'hFFFFFFFF);
    rdc(4'hF, 32'hFFFFFFFF, 32'h0);
    check(PIN_OE, 3'h0);
    lvl <= 3'h4;
    bus(1'b1, `SPCX_ADDR_PINDIR, 32'h2);
    check({PIN_OE, PIN_OUT[1]}, 4'h4);
    bus(1'b1, `SPCX_ADDR_PINDATA, 32'h3);
    check(PIN_OUT[1], 1'b1);
    repeat (4) @(posedge SYS_CLK);
    rdc(`SPCX_ADDR_PINDATA, 32'h7, 32'h7);
    run_clk <= 1'b1;
    seen = 2'h0;
    for (i = 0; i < 8; i = i + 1)
    begin
      bus(1'b0, `SPCX_ADDR_PINDATA, 32'h0);
      seen = seen | (2'h1 << q[2]);
    end
    check(seen, 2'h3);
    run_clk <= 1'b0;
    bus(1'b1, `SPCX_ADDR_CTRL, ie_il | ie_rx | ie_tx | ie_tm | ie_er);
    bus(1'b1, `SPCX_ADDR_PINFUNC, 32'h7);
    repeat (40) @(posedge SYS_CLK);
    check({IRQ, PIN_OE[2]}, 2'h1);
    bus(1'b1, `SPCX_ADDR_CTRL, t_en | ie_tx | dma);
    check({IRQ, DMA_REQ}, 2'h1);
    bus(1'b1, `SPCX_ADDR_CTRL, t_en | ie_tx);
    check(IRQ_SOURCE, `SPCX_SRC_TX);
    bus(1'b1, `SPCX_ADDR_TXDATA, 32'hA5);
    check(IRQ, 1'b0);
    i = 0;
    while (PIN_OUT[1] !== 1'b0 && i < 2000)
    begin
      @(posedge SYS_CLK);
      i = i + 1;
    end
    check(i >= 290 && i < 2000, 1'b1);
    repeat (16) @(posedge SYS_CLK);
    for (i = 0; i < 9; i = i + 1)
    begin
      repeat (32) @(posedge SYS_CLK);
      q[i] = PIN_OUT[1];
    end
    check(q[8:0], 9'h1A5);
    bus(1'b1, `SPCX_ADDR_CTRL, r_en | ie_il);
    repeat (400) @(posedge SYS_CLK);
    check(IRQ_SOURCE, `SPCX_SRC_IDLE);
    bus(1'b1, `SPCX_ADDR_ACK, 32'h0);
    check(IRQ, 1'b0);
    bus(1'b1, `SPCX_ADDR_CTRL, r_en | ie_il | ie_rx);
    far.send(8'h3C, 1'b1);
    repeat (400) @(posedge SYS_CLK);
    check(IRQ_SOURCE, `SPCX_SRC_RX);
    rdc(`SPCX_ADDR_RXDATA, 32'hFF, 32'h3C);
    check(IRQ_SOURCE, `SPCX_SRC_IDLE);
    bus(1'b1, `SPCX_ADDR_ACK, 32'h0);
    bus(1'b1, `SPCX_ADDR_CTRL, ie_rx);
    far.send(8'h11, 1'b1);
    repeat (40) @(posedge SYS_CLK);
    rdc(`SPCX_ADDR_STATUS, 32'h1 << `SPCX_ST_RDRF, 32'h0);
    bus(1'b1, `SPCX_ADDR_CTRL, r_en | ie_rx | ie_er);
    repeat (400) @(posedge SYS_CLK);
    far.send(8'h55, 1'b0);
    repeat (100) @(posedge SYS_CLK);
    check(IRQ_SOURCE, `SPCX_SRC_RXERR);
    bus(1'b0, `SPCX_ADDR_STATUS, 32'h0);
    rdc(`SPCX_ADDR_RXDATA, 32'hFF, 32'h55);
    check(IRQ, 1'b0);
    bus(1'b1, `SPCX_ADDR_CTRL, r_en | ie_tm);
    repeat (40) @(posedge SYS_CLK);
    check(IRQ_SOURCE, `SPCX_SRC_TIMER);
    bus(1'b1, `SPCX_ADDR_ACK, 32'h0);
    print_verdict;
  end
endmodule
